// file: hw/spv_pkg.sv
`default_nettype none
package spv_pkg;
   // memory address register width and bank split
   localparam int ADDR_W = 16;
   localparam int BANK_LSB = 12;
   localparam int BANK_W = ADDR_W - BANK_LSB;
   localparam int RAW_W = ADDR_W + 2;
   localparam int OP_W = 6;
   localparam int REG_AW = 4;
   localparam int DATA_W = 32;

   // op code values: internal interrupt call is fixed, the rest are plain
   // defaults to be matched to the sequencer's decoder
   localparam logic [OP_W-1:0] OP_INT_CALL = 6'h00;
   localparam logic [OP_W-1:0] OP_HALT = 6'h2e;
   localparam logic [OP_W-1:0] OP_LOAD_CTRL_REGS = 6'h33;
   localparam logic [OP_W-1:0] OP_PERIPH_XFER = 6'h24;
   localparam logic [OP_W-1:0] OP_PERIPH_CTRL_BR = 6'h25;
   localparam logic [OP_W-1:0] OP_STORE_IND = 6'h06;
   localparam logic [OP_W-1:0] OP_RESTORE_IND = 6'h07;
   localparam logic [OP_W-1:0] OP_RESUME_NORMAL = 6'h16;
   localparam logic [OP_W-1:0] OP_LOAD_BARRICADE = 6'h17;

   // register byte offsets
   localparam logic [REG_AW-1:0] CTRL_OFS = 4'h0;
   localparam logic [REG_AW-1:0] STATUS_OFS = 4'h4;
   localparam logic [REG_AW-1:0] INT_REG_OFS = 4'h8;
   localparam logic [REG_AW-1:0] SNAP_OFS = 4'hc;

   // control register fields
   localparam int CTRL_PROT_BIT = 0;
   localparam int CTRL_BYP_BIT = 1;
   localparam int CTRL_BANK_LSB = 8;

   // status and snapshot fields
   localparam int ST_OPV_BIT = 0;
   localparam int ST_IAV_BIT = 1;
   localparam int ST_EAV_BIT = 2;
   localparam int ST_PROT_BIT = 3;
   localparam int ST_BYP_BIT = 4;
   localparam int ST_MODE_LSB = 8;

   // reset values
   localparam logic PROT_RST = 1'b0;
   localparam logic BYP_RST = 1'b0;
   localparam logic [BANK_W-1:0] BANK_RST = 4'hf;
   localparam logic [ADDR_W-1:0] INT_REG_RST = 16'h0000;

   typedef enum logic [1:0] {
      SPV_STANDARD,
      SPV_INTERNAL,
      SPV_EXTERNAL
   } spv_mode_e;
endpackage
`default_nettype wire

// file: hw/spv_bound_check.sv
`timescale 1ns/100ps
`default_nettype none
module spv_bound_check #(
   parameter int RAW_W = 18,
   parameter int ADDR_W = 16,
   parameter int BANK_LSB = 12
) (
   input wire logic [RAW_W-1:0] raw_addr_in,
   input wire logic [ADDR_W-BANK_LSB-1:0] barricade_in,
   output logic [ADDR_W-1:0] wrapped_out,
   output logic protected_out
);
   assign wrapped_out = raw_addr_in[ADDR_W-1:0];
   assign protected_out = (wrapped_out[ADDR_W-1:BANK_LSB] >= barricade_in);
endmodule
`default_nettype wire

// file: hw/spv_protect.sv
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module spv_protect
   import spv_pkg::*;
#(
   parameter int RAW_W = spv_pkg::RAW_W
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [spv_pkg::REG_AW-1:0] reg_addr_in,
   input wire logic [spv_pkg::DATA_W-1:0] reg_wr_data_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [spv_pkg::DATA_W-1:0] reg_rd_data_out,
   input wire logic op_extract_in,
   input wire logic [spv_pkg::OP_W-1:0] op_code_in,
   input wire logic op_undefined_in,
   input wire logic op_not_installed_in,
   input wire logic fp_format_viol_in,
   input wire logic [spv_pkg::ADDR_W-1:0] op_addr_in,
   input wire logic [spv_pkg::ADDR_W-1:0] next_op_addr_in,
   input wire logic [RAW_W-1:0] a_addr_in,
   input wire logic parity_err_in,
   input wire logic [RAW_W-1:0] fail_addr_in,
   input wire logic int_opportunity_in,
   input wire logic [spv_pkg::ADDR_W-1:0] seq_reg_in,
   input wire logic ext_int_in,
   input wire logic resume_normal_op_in,
   input wire logic store_indicators_op_in,
   input wire logic restore_indicators_op_in,
   input wire logic restore_protect_in,
   input wire logic restore_bypass_in,
   input wire logic load_barricade_op_in,
   input wire logic [spv_pkg::BANK_W-1:0] barricade_bank_in,
   input wire logic int_reg_load_in,
   input wire logic [spv_pkg::ADDR_W-1:0] int_reg_data_in,
   output logic abort_out,
   output logic inhibit_xfer_out,
   output logic halt_out,
   output logic seq_load_out,
   output logic [spv_pkg::ADDR_W-1:0] seq_addr_out,
   output logic int_entry_out,
   output logic [1:0] mode_out,
   output logic [spv_pkg::ADDR_W-1:0] internal_interrupt_reg_out,
   output logic [4:0] indicators_out
);
   import spv_pkg::*;

   spv_mode_e mode;
   logic protect;
   logic bypass;
   logic [BANK_W-1:0] barricade;
   logic [ADDR_W-1:0] internal_interrupt_reg;
   logic op_viol;
   logic int_addr_viol;
   logic ext_addr_viol;
   logic [DATA_W-1:0] snapshot;

   logic [ADDR_W-1:0] a_wrapped;
   logic [ADDR_W-1:0] fail_wrapped;
   logic a_in_prot;
   logic fail_in_prot;

   logic protect_active;
   logic prohibited;
   logic privileged;
   logic is_xfer;
   logic forced_check;
   logic next_set_opv;
   logic next_set_iav;
   logic next_set_eav;
   logic next_abort;
   logic next_inhibit;
   logic next_halt;
   logic next_seq_load;
   logic [ADDR_W-1:0] next_seq_addr;
   logic take_int;
   logic violation_pending;
   logic [DATA_W-1:0] next_rd_data;

   spv_bound_check #(
      .RAW_W(RAW_W),
      .ADDR_W(ADDR_W),
      .BANK_LSB(BANK_LSB)
   ) u_a_check (
      .raw_addr_in(a_addr_in),
      .barricade_in(barricade),
      .wrapped_out(a_wrapped),
      .protected_out(a_in_prot)
   );

   spv_bound_check #(
      .RAW_W(RAW_W),
      .ADDR_W(ADDR_W),
      .BANK_LSB(BANK_LSB)
   ) u_fail_check (
      .raw_addr_in(fail_addr_in),
      .barricade_in(barricade),
      .wrapped_out(fail_wrapped),
      .protected_out(fail_in_prot)
   );

   assign protect_active = protect && (mode == SPV_STANDARD);
   assign is_xfer = (op_code_in == OP_PERIPH_XFER);
   assign forced_check = bypass && is_xfer && (mode != SPV_STANDARD);
   assign violation_pending = op_viol || int_addr_viol;

   always_comb begin
      case (op_code_in)
         OP_HALT, OP_LOAD_CTRL_REGS, OP_PERIPH_XFER, OP_PERIPH_CTRL_BR,
         OP_STORE_IND, OP_RESTORE_IND, OP_RESUME_NORMAL,
         OP_LOAD_BARRICADE: prohibited = 1'b1;
         OP_INT_CALL: prohibited = 1'b1;
         default: prohibited = 1'b0;
      endcase
      privileged = prohibited || op_undefined_in || op_not_installed_in ||
                   fp_format_viol_in;
   end

   always_comb begin
      next_set_opv = 1'b0;
      next_set_iav = 1'b0;
      next_set_eav = 1'b0;
      next_abort = 1'b0;
      next_inhibit = 1'b0;
      next_halt = 1'b0;
      next_seq_load = 1'b0;
      next_seq_addr = seq_reg_in;
      take_int = 1'b0;
      if (op_extract_in) begin
         if (protect_active && privileged && !bypass) begin
            // trap and rewind to op code
            next_set_opv = 1'b1;
            next_abort = 1'b1;
            next_seq_load = 1'b1;
            next_seq_addr = op_addr_in;
         end else if (protect_active && bypass && is_xfer && a_in_prot) begin
            next_set_iav = 1'b1;
            next_abort = 1'b1;
            next_seq_load = 1'b1;
            next_seq_addr = next_op_addr_in;
         end else if (forced_check && a_in_prot) begin
            next_abort = 1'b1;
            next_seq_load = 1'b1;
            next_seq_addr = next_op_addr_in;
            if (mode == SPV_INTERNAL) begin
               next_set_iav = 1'b1;
            end else begin
               next_set_eav = 1'b1;
            end
         end
      end else if (int_opportunity_in && (mode == SPV_STANDARD) &&
                   violation_pending && !ext_int_in) begin
         take_int = 1'b1;
         next_seq_load = 1'b1;
         next_seq_addr = internal_interrupt_reg;
      end else if (resume_normal_op_in && (mode != SPV_STANDARD)) begin
         next_seq_load = 1'b1;
         next_seq_addr = internal_interrupt_reg;
      end
      if (parity_err_in) begin
         if (protect_active && fail_in_prot) begin
            next_set_iav = 1'b1;
            next_abort = 1'b1;
            next_inhibit = 1'b1;
         end else begin
            next_halt = 1'b1;
         end
      end
   end

   // processor mode
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         mode <= SPV_STANDARD;
      end else begin
         case (mode)
            SPV_STANDARD: begin
               if (ext_int_in) begin
                  mode <= SPV_EXTERNAL;
               end else if (take_int) begin
                  mode <= SPV_INTERNAL;
               end
            end
            SPV_INTERNAL: begin
               if (ext_int_in) begin
                  mode <= SPV_EXTERNAL;
               end else if (resume_normal_op_in) begin
                  mode <= SPV_STANDARD;
               end
            end
            SPV_EXTERNAL: begin
               if (resume_normal_op_in) begin
                  mode <= SPV_STANDARD;
               end
            end
            default: mode <= SPV_STANDARD;
         endcase
      end
   end

   // protect indicator and barricade bank
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         protect <= PROT_RST;
         barricade <= BANK_RST;
      end else begin
         if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
            protect <= reg_wr_data_in[CTRL_PROT_BIT];
            barricade <= reg_wr_data_in[CTRL_BANK_LSB +: BANK_W];
         end
         if (restore_indicators_op_in) begin
            protect <= restore_protect_in;
         end
         if (load_barricade_op_in) begin
            barricade <= barricade_bank_in;
         end
      end
   end

   // one-shot bypass
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         bypass <= BYP_RST;
      end else begin
         if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
            bypass <= reg_wr_data_in[CTRL_BYP_BIT];
         end
         if (op_extract_in && mode == SPV_STANDARD) begin
            bypass <= 1'b0;
         end else if (store_indicators_op_in && mode != SPV_STANDARD) begin
            bypass <= 1'b0;
         end
         if (restore_indicators_op_in) begin
            bypass <= restore_bypass_in;
         end
      end
   end

   // interrupt register, swapped on entry
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         internal_interrupt_reg <= INT_REG_RST;
      end else if (take_int) begin
         internal_interrupt_reg <= seq_reg_in;
      end else if (int_reg_load_in) begin
         internal_interrupt_reg <= int_reg_data_in;
      end else if (reg_wr_in && reg_addr_in == INT_REG_OFS) begin
         internal_interrupt_reg <= reg_wr_data_in[ADDR_W-1:0];
      end
   end

   // violation indicators, set wins over clear
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         op_viol <= 1'b0;
         int_addr_viol <= 1'b0;
         ext_addr_viol <= 1'b0;
      end else begin
         op_viol <= next_set_opv || (op_viol && !store_indicators_op_in);
         int_addr_viol <= next_set_iav ||
                          (int_addr_viol && !store_indicators_op_in);
         ext_addr_viol <= next_set_eav ||
                          (ext_addr_viol && !store_indicators_op_in);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         snapshot <= '0;
      end else if (store_indicators_op_in) begin
         snapshot <= '0;
         snapshot[ST_OPV_BIT] <= op_viol;
         snapshot[ST_IAV_BIT] <= int_addr_viol;
         snapshot[ST_EAV_BIT] <= ext_addr_viol;
         snapshot[ST_PROT_BIT] <= protect;
         snapshot[ST_BYP_BIT] <= bypass;
         snapshot[ST_MODE_LSB +: 2] <= mode;
      end
   end

   // sequencer-facing pulses
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         abort_out <= 1'b0;
         inhibit_xfer_out <= 1'b0;
         halt_out <= 1'b0;
         seq_load_out <= 1'b0;
         seq_addr_out <= '0;
         int_entry_out <= 1'b0;
      end else begin
         abort_out <= next_abort;
         inhibit_xfer_out <= next_inhibit;
         halt_out <= next_halt;
         seq_load_out <= next_seq_load;
         seq_addr_out <= next_seq_load ? next_seq_addr : '0;
         int_entry_out <= take_int;
      end
   end

   always_comb begin
      next_rd_data = '0;
      case (reg_addr_in)
         CTRL_OFS: begin
            next_rd_data[CTRL_PROT_BIT] = protect;
            next_rd_data[CTRL_BYP_BIT] = bypass;
            next_rd_data[CTRL_BANK_LSB +: BANK_W] = barricade;
         end
         STATUS_OFS: begin
            next_rd_data[ST_OPV_BIT] = op_viol;
            next_rd_data[ST_IAV_BIT] = int_addr_viol;
            next_rd_data[ST_EAV_BIT] = ext_addr_viol;
            next_rd_data[ST_PROT_BIT] = protect;
            next_rd_data[ST_BYP_BIT] = bypass;
            next_rd_data[ST_MODE_LSB +: 2] = mode;
         end
         INT_REG_OFS: next_rd_data[ADDR_W-1:0] = internal_interrupt_reg;
         SNAP_OFS: next_rd_data = snapshot;
         default: next_rd_data = '0;
      endcase
   end

   // read data valid one cycle after strobe only
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         reg_rd_data_out <= '0;
      end else if (reg_rd_in) begin
         reg_rd_data_out <= next_rd_data;
      end else begin
         reg_rd_data_out <= '0;
      end
   end

   assign mode_out = mode;
   assign internal_interrupt_reg_out = internal_interrupt_reg;
   assign indicators_out = {bypass, protect, ext_addr_viol, int_addr_viol,
                            op_viol};

endmodule
`default_nettype wire

// file: bench/spv_protect_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module spv_protect_monitor
   import spv_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic op_extract_in,
   input wire logic [spv_pkg::OP_W-1:0] op_code_in,
   input wire logic op_undefined_in,
   input wire logic op_not_installed_in,
   input wire logic fp_format_viol_in,
   input wire logic [spv_pkg::ADDR_W-1:0] op_addr_in,
   input wire logic [spv_pkg::ADDR_W-1:0] seq_reg_in,
   input wire logic parity_err_in,
   input wire logic ext_int_in,
   input wire logic resume_normal_op_in,
   input wire logic store_indicators_op_in,
   input wire logic restore_indicators_op_in,
   input wire logic abort_out,
   input wire logic inhibit_xfer_out,
   input wire logic halt_out,
   input wire logic seq_load_out,
   input wire logic [spv_pkg::ADDR_W-1:0] seq_addr_out,
   input wire logic int_entry_out,
   input wire logic [1:0] mode_out,
   input wire logic [spv_pkg::ADDR_W-1:0] internal_interrupt_reg_out,
   input wire logic [4:0] indicators_out
);
   logic priv;
   logic prot_std;
   assign priv = op_undefined_in | op_not_installed_in | fp_format_viol_in
      | (op_code_in inside {OP_INT_CALL, OP_HALT, OP_LOAD_CTRL_REGS,
      OP_PERIPH_XFER, OP_PERIPH_CTRL_BR, OP_STORE_IND, OP_RESTORE_IND,
      OP_RESUME_NORMAL, OP_LOAD_BARRICADE});
   assign prot_std = indicators_out[3] && mode_out == 2'h0;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_priv_trap: assert property (
      op_extract_in && priv && prot_std && !indicators_out[4] |=> abort_out
      && seq_load_out && indicators_out[0] && seq_addr_out == $past(op_addr_in))
      else $error("privileged op not trapped");
   a_no_check: assert property (
      op_extract_in && mode_out == 2'h0 && indicators_out[4:3] == 2'h0
      && !parity_err_in |=> !abort_out)
      else $error("abort without protection");
   a_parity_halt: assert property (
      parity_err_in && !prot_std |=> halt_out && !inhibit_xfer_out)
      else $error("unprotected parity error did not halt");
   a_inhibit_set: assert property (
      inhibit_xfer_out |-> abort_out && !halt_out && indicators_out[1])
      else $error("inhibit without address violation");
   a_entry_swap: assert property (
      int_entry_out |-> mode_out == 2'h1 && seq_load_out
      && seq_addr_out == $past(internal_interrupt_reg_out)
      && internal_interrupt_reg_out == $past(seq_reg_in))
      else $error("interrupt entry did not swap");
   a_entry_cause: assert property (
      int_entry_out |-> $past(mode_out) == 2'h0 && !$past(ext_int_in)
      && $past(indicators_out[1:0]) != 2'h0 && !$past(op_extract_in))
      else $error("interrupt entry without cause");
   a_resume_jump: assert property (
      resume_normal_op_in && mode_out != 2'h0 && !op_extract_in && !ext_int_in
      |=> mode_out == 2'h0 && seq_load_out
      && seq_addr_out == $past(internal_interrupt_reg_out))
      else $error("resume did not jump");
   a_store_clear: assert property (
      store_indicators_op_in && !op_extract_in && !parity_err_in
      |=> indicators_out[2:0] == 3'h0)
      else $error("store indicators left a flag");
   a_bypass_drop: assert property (
      op_extract_in && mode_out == 2'h0 && !restore_indicators_op_in
      |=> !indicators_out[4])
      else $error("bypass survived extraction");
   a_ext_flag: assert property (
      abort_out && mode_out == 2'h2 |-> indicators_out[2] && !int_entry_out)
      else $error("external abort without flag");
   c_entry: cover property (int_entry_out);
   c_inhibit: cover property (inhibit_xfer_out);
   c_ext_abort: cover property (abort_out && mode_out == 2'h2);
endmodule
bind spv_protect spv_protect_monitor u_monitor (.*);
`default_nettype wire

// file: bench/spv_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module spv_seq_model #(
   parameter logic [15:0] START = 16'h0100,
   parameter logic [15:0] LEN = 16'h0008,
   parameter logic [15:0] MEM_TOP = 16'h4000
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic issue_in,
   input wire logic [5:0] op_in,
   input wire logic rd_in,
   input wire logic [17:0] rd_addr_in,
   input wire logic seq_load_in,
   input wire logic [15:0] seq_addr_in,
   output logic op_extract_out,
   output logic [5:0] op_code_out,
   output logic [15:0] op_addr_out,
   output logic [15:0] next_op_addr_out,
   output logic [15:0] seq_reg_out,
   output logic parity_err_out,
   output logic [17:0] fail_addr_out
);
   // op code shows garbage outside extraction
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         seq_reg_out <= START;
         op_extract_out <= 1'b0;
         op_code_out <= 6'h00;
      end else begin
         op_extract_out <= issue_in;
         op_code_out <= issue_in ? op_in : ~op_code_out;
         if (seq_load_in) begin
            seq_reg_out <= seq_addr_in;
         end else if (issue_in) begin
            op_addr_out <= seq_reg_out;
            next_op_addr_out <= seq_reg_out + LEN;
            seq_reg_out <= seq_reg_out + LEN;
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         parity_err_out <= 1'b0;
         fail_addr_out <= 18'h00000;
      end else begin
         parity_err_out <= rd_in && rd_addr_in[15:0] >= MEM_TOP;
         fail_addr_out <= rd_in ? rd_addr_in : ~fail_addr_out;
      end
   end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import spv_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, iss = 1'b0;
   logic mrd = 1'b0, lb = 1'b0, ext = 1'b0, opp = 1'b0, rn = 1'b0;
   logic [2:0] und = 3'h0;
   logic si = 1'b0, ri = 1'b0, rp = 1'b0, rb = 1'b0, iirl = 1'b0;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0, rdd;
   logic [5:0] op = 6'h00, mop;
   logic [17:0] aa = 18'h0, ma = 18'h0, mfa;
   logic [15:0] iid = 16'h0, moa, mnx, msq, sa, irg, s;
   logic mx, mpe, ab, ih, hl, sl, ie;
   logic [1:0] md;
   logic [4:0] ind;
   logic [5:0] tops [13] = '{OP_INT_CALL, OP_HALT, OP_LOAD_CTRL_REGS,
      OP_PERIPH_XFER, OP_PERIPH_CTRL_BR, OP_STORE_IND, OP_RESTORE_IND,
      OP_RESUME_NORMAL, OP_LOAD_BARRICADE, 6'h01, 6'h01, 6'h01, 6'h01};
   int n_mismatch = 0, samples_checked = 0;
   always #2.5 clk = ~clk;
   spv_protect DUT (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(ra),
      .reg_wr_data_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rd_data_out(rdd), .op_extract_in(mx), .op_code_in(mop),
      .op_undefined_in(und[0]), .op_not_installed_in(und[1]),
      .fp_format_viol_in(und[2]), .op_addr_in(moa), .next_op_addr_in(mnx),
      .a_addr_in(aa), .parity_err_in(mpe), .fail_addr_in(mfa),
      .int_opportunity_in(opp), .seq_reg_in(msq), .ext_int_in(ext),
      .resume_normal_op_in(rn), .store_indicators_op_in(si),
      .restore_indicators_op_in(ri), .restore_protect_in(rp),
      .restore_bypass_in(rb), .load_barricade_op_in(lb),
      .barricade_bank_in(4'h9), .int_reg_load_in(iirl),
      .int_reg_data_in(iid),
      .abort_out(ab), .inhibit_xfer_out(ih), .halt_out(hl),
      .seq_load_out(sl), .seq_addr_out(sa), .int_entry_out(ie),
      .mode_out(md), .internal_interrupt_reg_out(irg), .indicators_out(ind));
   spv_seq_model u_seq (.clk_in(clk), .rst_n_in(rst_n), .issue_in(iss),
      .op_in(op), .rd_in(mrd), .rd_addr_in(ma), .seq_load_in(sl),
      .seq_addr_in(sa), .op_extract_out(mx), .op_code_out(mop),
      .op_addr_out(moa), .next_op_addr_out(mnx), .seq_reg_out(msq),
      .parity_err_out(mpe), .fail_addr_out(mfa));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdd, e);
   endtask
   // outputs seen one cycle after the request edge
   task automatic go(input logic [11:0] e);
      @(posedge clk);
      {ext, opp, rn, si, ri, iirl, und, iss, mrd, lb} <= 12'h000;
      #1 chk({20'h0, ab, ih, hl, sl, ie, md, ind}, {20'h0, e});
   endtask
   task automatic xt(input logic [5:0] o, input logic [2:0] u,
      input logic [11:0] e);
      @(posedge clk);
      iss <= 1'b1;
      op <= o;
      und <= u;
      @(posedge clk);
      iss <= 1'b0;
      go(e);
   endtask
   // memory answers one cycle after the read request
   task automatic mr(input logic [17:0] a, input logic [11:0] e);
      ma <= a;
      mrd <= 1'b1;
      @(posedge clk);
      mrd <= 1'b0;
      go(e);
   endtask
   task automatic conclude;
      $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      conclude;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 rreg(CTRL_OFS, 32'h0f00);
      rreg(STATUS_OFS, 32'h0);
      rreg(INT_REG_OFS, 32'h0);
      rreg(4'h2, 32'h0);
      wreg(STATUS_OFS, 32'hffffffff);
      rreg(STATUS_OFS, 32'h0);
      $display("test registers done");
      xt(OP_INT_CALL, 3'h0, 12'h000);
      mr(18'h09000, 12'h200);
      wreg(CTRL_OFS, 32'h0801);
      for (int i = 0; i < 13; i++) begin
         xt(tops[i], (i > 8 && i < 12) ? 3'h1 << (i - 9) : 3'h0,
            (i < 12) ? 12'h909 : 12'h008);
         if (i < 12) begin
            chk(sa, moa);
            si <= 1'b1;
            go(12'h008);
         end
      end
      $display("test op code trap done");
      wreg(INT_REG_OFS, 32'h0400);
      xt(OP_INT_CALL, 3'h0, 12'h909);
      s = moa;
      @(posedge clk);
      opp <= 1'b1;
      go(12'h1a9);
      chk(sa, 16'h0400);
      chk(irg, s);
      xt(OP_HALT, 3'h0, 12'h029);
      iid <= s + 16'h0008;
      iirl <= 1'b1;
      go(12'h029);
      si <= 1'b1;
      go(12'h028);
      rreg(SNAP_OFS, 32'h0109);
      {ri, rp, rb} <= 3'h7;
      go(12'h038);
      aa <= 18'h08010;
      xt(OP_PERIPH_XFER, 3'h0, 12'h93a);
      chk(sa, mnx);
      si <= 1'b1;
      go(12'h028);
      ext <= 1'b1;
      go(12'h048);
      {ri, rp, rb} <= 3'h7;
      go(12'h058);
      xt(OP_PERIPH_XFER, 3'h0, 12'h95c);
      chk(sa, mnx);
      rn <= 1'b1;
      go(12'h11c);
      chk(sa, s + 16'h0008);
      $display("test interrupt modes done");
      xt(OP_HALT, 3'h0, 12'h00c);
      si <= 1'b1;
      go(12'h008);
      {ri, rp, rb} <= 3'h7;
      go(12'h018);
      xt(OP_PERIPH_XFER, 3'h0, 12'h90a);
      si <= 1'b1;
      go(12'h008);
      mr(18'h09000, 12'hc0a);
      si <= 1'b1;
      go(12'h008);
      mr(18'h15000, 12'h208);
      lb <= 1'b1;
      go(12'h008);
      rreg(CTRL_OFS, 32'h0901);
      mr(18'h08000, 12'h208);
      $display("test bypass and parity done");
      conclude;
   end
endmodule
`default_nettype wire
